// file: qsp_buf.sv
package qsp_pkg;
  localparam int NUM_PORTS = 4;              // serial ports in the block
  localparam int NUM_LANES = 8;              // two data lanes per port
  localparam int WORD_W    = 32;             // dma word width
  // register index, byte address is port*16 + index*4
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_DIV  = 2'h1;
  localparam logic [1:0] REG_STAT = 2'h2;
  // control field positions
  localparam int CTRL_EN      = 0;           // port enable
  localparam int CTRL_DIR0    = 1;           // lane 0 transmits when set, lane 1 next bit up
  localparam int CTRL_MODE_LO = 3;           // two bits of mode
  localparam int CTRL_LSBF    = 5;           // lsb first when set
  localparam int CTRL_WL_LO   = 6;           // five bits, word length minus one
  localparam int CTRL_CMP_LO  = 11;          // two bits of companding
  localparam int CTRL_ICLK    = 13;          // bit clock made here
  localparam int CTRL_IFS     = 14;          // frame sync made here
  localparam int CTRL_SLOT_LO = 15;          // three bits, tdm words per frame minus one
  localparam logic [31:0] CTRL_MASK  = 32'h0003_ffff;
  localparam logic [31:0] CTRL_RESET = 32'h0000_07c0;  // disabled, 32-bit words
  localparam logic [15:0] DIV_RESET  = 16'h0004;       // half period minus one, core cycles
  localparam logic [15:0] DIV_MIN    = 16'h0000;       // one core cycle per half bit
  // modes and companding
  localparam logic [1:0] MODE_STD = 2'h0;
  localparam logic [1:0] MODE_TDM = 2'h1;
  localparam logic [1:0] MODE_I2S = 2'h2;
  localparam logic [1:0] CMP_OFF  = 2'h0;
  localparam logic [1:0] CMP_MU   = 2'h1;
  localparam logic [1:0] CMP_A    = 2'h2;
  localparam logic [4:0] WL_MIN_STD = 5'h02;  // three bits
  localparam logic [4:0] WL_MIN_I2S = 5'h07;  // eight bits
  // status field positions: enable, busy, frame sync level, underrun[4:3], overflow[6:5]
  localparam int STAT_STK_LO = 3;
  // companding constants
  localparam logic [15:0] MU_BIAS   = 16'h0084;
  localparam logic [15:0] MU_CLIP   = 16'h7f7b;
  localparam logic [15:0] A_CLIP    = 16'h7fff;
  localparam logic [15:0] A_SEG_OFS = 16'h0100;
  localparam logic [7:0]  A_XOR_NEG = 8'h55;
  localparam logic [7:0]  A_XOR_POS = 8'hd5;
endpackage : qsp_pkg

`timescale 1ns/1ns
// two-entry buffer; outputs straight from flops so a stall loses no word
module qsp_buf2 #(
  parameter int WIDTH = 32                   // word width
) (
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output wire logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output wire logic             out_valid,
  input  wire logic             out_ready,
  output wire logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] d0_reg, d0_next;        // head word, drives out_data
  logic [WIDTH-1:0] d1_reg, d1_next;        // second word
  logic [1:0]       cnt_reg, cnt_next;      // words held
  logic             vld_reg, vld_next;      // not empty
  logic             rdy_reg, rdy_next;      // not full
  logic             push;
  logic             pop;

  if (WIDTH < 1) begin : g_chk
    $error("qsp_buf2 width must be positive");
  end

  // pop first so a one-word buffer can take a word in the same cycle it gives one; a full buffer takes none
  always_comb begin
    push     = in_valid && rdy_reg;
    pop      = vld_reg && out_ready;
    d0_next  = d0_reg;
    d1_next  = d1_reg;
    cnt_next = cnt_reg;
    if (pop) begin
      d0_next  = d1_reg;
      cnt_next = cnt_reg - 2'h1;
    end
    if (push) begin
      if (cnt_next == 2'h0) d0_next = in_data;
      else d1_next = in_data;
      cnt_next = cnt_next + 2'h1;
    end
    vld_next = cnt_next != 2'h0;
    rdy_next = cnt_next != 2'h2;
  end

  // registers only
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      d0_reg  <= '0;
      d1_reg  <= '0;
      cnt_reg <= 2'h0;
      vld_reg <= 1'b0;
      rdy_reg <= 1'b1;
    end else begin
      d0_reg  <= d0_next;
      d1_reg  <= d1_next;
      cnt_reg <= cnt_next;
      vld_reg <= vld_next;
      rdy_reg <= rdy_next;
    end
  end

  assign in_ready  = rdy_reg;
  assign out_valid = vld_reg;
  assign out_data  = d0_reg;
endmodule : qsp_buf2

// file: qsp_top.sv
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
// four synchronous serial ports behind a plain register port, with per-lane dma streams
module qsp_top (
  input  wire logic                                              core_clk,
  input  wire logic                                              rst_b,
  input  wire logic [5:0]                                        reg_addr,
  input  wire logic [31:0]                                       reg_wdata,
  input  wire logic                                              reg_wr,
  input  wire logic                                              reg_rd,
  output wire logic [31:0]                                       reg_rdata,
  input  wire logic [qsp_pkg::NUM_PORTS-1:0]                     sclk_i,
  output wire logic [qsp_pkg::NUM_PORTS-1:0]                     sclk_o,
  output wire logic [qsp_pkg::NUM_PORTS-1:0]                     sclk_oe,
  input  wire logic [qsp_pkg::NUM_PORTS-1:0]                     fs_i,
  output wire logic [qsp_pkg::NUM_PORTS-1:0]                     fs_o,
  output wire logic [qsp_pkg::NUM_PORTS-1:0]                     fs_oe,
  input  wire logic [qsp_pkg::NUM_LANES-1:0]                     dat_i,
  output wire logic [qsp_pkg::NUM_LANES-1:0]                     dat_o,
  output wire logic [qsp_pkg::NUM_LANES-1:0]                     dat_oe,
  input  wire logic [qsp_pkg::NUM_LANES-1:0][qsp_pkg::WORD_W-1:0] dma_tx_data,
  input  wire logic [qsp_pkg::NUM_LANES-1:0]                     dma_tx_valid,
  output wire logic [qsp_pkg::NUM_LANES-1:0]                     dma_tx_ready,
  output wire logic [qsp_pkg::NUM_LANES-1:0][qsp_pkg::WORD_W-1:0] dma_rx_data,
  output wire logic [qsp_pkg::NUM_LANES-1:0]                     dma_rx_valid,
  input  wire logic [qsp_pkg::NUM_LANES-1:0]                     dma_rx_ready
);
  localparam int NP = qsp_pkg::NUM_PORTS;

  logic [31:0] ctrl_a [NP];                 // per-port control, for read back
  logic [31:0] div_a  [NP];                 // per-port divider, for read back
  logic [31:0] stat_a [NP];                 // per-port status, for read back
  wire         rise_a [NP];                 // bit clock rising event per port
  wire         fall_a [NP];                 // bit clock falling event per port
  wire         fsv_a  [NP];                 // frame sync level seen by each port
  logic [31:0] rdata_reg, rdata_next;       // read data, valid the cycle after reg_rd

  // linear 16-bit to 8-bit companded code
  function automatic logic [7:0] qsp_compress(input logic [15:0] x, input logic alaw);
    logic        sgn;
    logic [15:0] mag;
    logic [2:0]  ex;
    logic [3:0]  mt;
    logic [7:0]  r;
    sgn = x[15];
    mag = sgn ? 16'(~x + 16'h0001) : x;
    ex  = 3'h0;
    if (alaw) begin
      if (mag > qsp_pkg::A_CLIP) mag = qsp_pkg::A_CLIP;
      for (int i = 1; i < 8; i++) if (mag[i+7]) ex = 3'(i);
      mt = (ex == 3'h0) ? mag[7:4] : 4'(mag >> (4'(ex) + 4'h3));
      r  = {1'b0, ex, mt} ^ (sgn ? qsp_pkg::A_XOR_NEG : qsp_pkg::A_XOR_POS);
    end else begin
      if (mag > qsp_pkg::MU_CLIP) mag = qsp_pkg::MU_CLIP;
      mag = 16'(mag + qsp_pkg::MU_BIAS);
      for (int i = 0; i < 8; i++) if (mag[i+7]) ex = 3'(i);
      mt = 4'(mag >> (4'(ex) + 4'h3));
      r  = ~{sgn, ex, mt};
    end
    return r;
  endfunction : qsp_compress

  // 8-bit companded code back to a sign-extended linear word
  function automatic logic [31:0] qsp_expand(input logic [7:0] b, input logic alaw);
    logic [7:0]  c;
    logic [15:0] t;
    logic        neg;
    if (alaw) begin
      c   = b ^ qsp_pkg::A_XOR_NEG;
      t   = {8'h00, c[3:0], 4'h8};
      if (c[6:4] != 3'h0) t = 16'((t + qsp_pkg::A_SEG_OFS) << 3'(c[6:4] - 3'h1));
      neg = !c[7];
    end else begin
      c   = ~b;
      t   = 16'((({12'h000, c[3:0]} << 3) + qsp_pkg::MU_BIAS) << c[6:4]);
      t   = 16'(t - qsp_pkg::MU_BIAS);
      neg = c[7];
    end
    return neg ? 32'(32'h0 - {16'h0000, t}) : {16'h0000, t};
  endfunction : qsp_expand

  // read mux; unmapped index 3 reads zero, the slave never stalls
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr[3:2])
        qsp_pkg::REG_CTRL: rdata_next = ctrl_a[reg_addr[5:4]];
        qsp_pkg::REG_DIV:  rdata_next = div_a[reg_addr[5:4]];
        qsp_pkg::REG_STAT: rdata_next = stat_a[reg_addr[5:4]];
        default:           rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) rdata_reg <= 32'h0000_0000;
    else rdata_reg <= rdata_next;
  end
  assign reg_rdata = rdata_reg;

  genvar p, l;
  for (p = 0; p < NP; p++) begin : g_port
    localparam int PT = (p >= 2) ? p - 2 : p;  // partner port that owns tdm timing
    logic [31:0] ctrl_reg, ctrl_next;       // configuration
    logic [15:0] div_reg, div_next;         // internal clock half period minus one
    logic [3:0]  stk_reg, stk_next;         // sticky underrun and overflow per lane
    logic [3:0]  sy1_reg, sy1_next;         // first sync stage: data1, data0, fs, sclk
    logic [3:0]  sy2_reg, sy2_next;         // second sync stage, the only one read
    logic        ckl_reg, ckl_next;         // previous synced clock level for edges
    logic [15:0] dcnt_reg, dcnt_next;       // clock divider count
    logic        sco_reg, sco_next;         // bit clock driven out
    logic        scoe_reg, scoe_next;       // bit clock enable
    logic        act_reg, act_next;         // inside a word
    logic [4:0]  bit_reg, bit_next;         // bit within word
    logic [2:0]  slot_reg, slot_next;       // tdm word within frame
    logic        fsl_reg, fsl_next;         // frame sync level at last rising edge
    logic        fso_reg, fso_next;         // frame sync driven out
    logic        fsoe_reg, fsoe_next;       // frame sync enable
    logic        en, iclk, ifs, lsbf, tslave, tgl, rise, fall, fsv, done, lastw, fstart, load;
    logic [1:0]  mode, cmp;
    logic [4:0]  wl;                        // effective length minus one
    wire  [1:0]  urun_v;                    // lane underrun events
    wire  [1:0]  ovf_v;                     // lane overflow events
    wire         sel;

    assign sel = reg_addr[5:4] == 2'(p);

    // field decode with word length floors per mode
    always_comb begin
      en     = ctrl_reg[qsp_pkg::CTRL_EN];
      mode   = ctrl_reg[qsp_pkg::CTRL_MODE_LO +: 2];
      lsbf   = ctrl_reg[qsp_pkg::CTRL_LSBF];
      cmp    = ctrl_reg[qsp_pkg::CTRL_CMP_LO +: 2];
      iclk   = ctrl_reg[qsp_pkg::CTRL_ICLK];
      ifs    = ctrl_reg[qsp_pkg::CTRL_IFS];
      tslave = (p >= 2) && (mode == qsp_pkg::MODE_TDM);
      wl     = ctrl_reg[qsp_pkg::CTRL_WL_LO +: 5];
      if (mode == qsp_pkg::MODE_I2S) begin
        if (wl < qsp_pkg::WL_MIN_I2S) wl = qsp_pkg::WL_MIN_I2S;
      end else if (wl < qsp_pkg::WL_MIN_STD) wl = qsp_pkg::WL_MIN_STD;
    end

    // configuration is frozen while enabled, only the enable bit can change
    always_comb begin
      ctrl_next = ctrl_reg;
      div_next  = div_reg;
      stk_next  = stk_reg;
      if (reg_wr && sel && reg_addr[3:2] == qsp_pkg::REG_CTRL) begin
        if (en) ctrl_next = {ctrl_reg[31:1], reg_wdata[0]};
        else ctrl_next = reg_wdata & qsp_pkg::CTRL_MASK;
      end
      if (reg_wr && sel && reg_addr[3:2] == qsp_pkg::REG_DIV && !en) div_next = reg_wdata[15:0];
      // write one clears; a new event in the same cycle wins
      if (reg_wr && sel && reg_addr[3:2] == qsp_pkg::REG_STAT) stk_next = stk_reg & ~reg_wdata[6:3];
      stk_next = stk_next | {ovf_v, urun_v};
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        ctrl_reg <= qsp_pkg::CTRL_RESET;
        div_reg  <= qsp_pkg::DIV_RESET;
        stk_reg  <= 4'h0;
      end else begin
        ctrl_reg <= ctrl_next;
        div_reg  <= div_next;
        stk_reg  <= stk_next;
      end
    end

    // pin synchronisers; the first stage feeds only the second
    always_comb begin
      sy1_next = {dat_i[2*p+1], dat_i[2*p], fs_i[p], sclk_i[p]};
      sy2_next = sy1_reg;
      ckl_next = sy2_reg[0];
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        sy1_reg <= 4'hf;
        sy2_reg <= 4'hf;
        ckl_reg <= 1'b1;
      end else begin
        sy1_reg <= sy1_next;
        sy2_reg <= sy2_next;
        ckl_reg <= ckl_next;
      end
    end

    // internal bit clock: a zero divider toggles every core cycle, which is half rate
    always_comb begin
      tgl       = en && iclk && !tslave && (dcnt_reg >= div_reg);
      dcnt_next = (!en || tgl) ? 16'h0000 : 16'(dcnt_reg + 16'h0001);
      sco_next  = (en && iclk && !tslave) ? (sco_reg ^ tgl) : 1'b0;
      scoe_next = en && iclk && !tslave;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        dcnt_reg <= 16'h0000;
        sco_reg  <= 1'b0;
        scoe_reg <= 1'b0;
      end else begin
        dcnt_reg <= dcnt_next;
        sco_reg  <= sco_next;
        scoe_reg <= scoe_next;
      end
    end

    // own edges: divider toggles, or edges found in the sampled external clock
    assign rise_a[p] = iclk ? (tgl && !sco_reg) : (sy2_reg[0] && !ckl_reg);
    assign fall_a[p] = iclk ? (tgl && sco_reg) : (!sy2_reg[0] && ckl_reg);
    assign fsv_a[p]  = ifs ? fso_reg : sy2_reg[1];

    // frame timing; a tdm transmitter port follows its partner's clock and frame
    always_comb begin
      rise   = en && (tslave ? rise_a[PT] : rise_a[p]);
      fall   = en && (tslave ? fall_a[PT] : fall_a[p]);
      fsv    = tslave ? fsv_a[PT] : fsv_a[p];
      done   = act_reg && (bit_reg == wl);
      lastw  = (mode != qsp_pkg::MODE_TDM) || (slot_reg == ctrl_reg[qsp_pkg::CTRL_SLOT_LO +: 3]);
      // word select change starts the next word one bit later; else a high sync
      if (mode == qsp_pkg::MODE_I2S) fstart = rise && (fsv != fsl_reg);
      else fstart = rise && fsv && (!act_reg || (done && lastw));
      load      = fstart || (rise && done && !lastw);
      act_next  = act_reg;
      bit_next  = bit_reg;
      slot_next = slot_reg;
      fsl_next  = rise ? fsv : fsl_reg;
      fso_next  = fso_reg;
      fsoe_next = en && ifs && !tslave;
      if (fstart) begin
        act_next  = 1'b1;
        bit_next  = 5'h00;
        slot_next = 3'h0;
      end else if (rise && done) begin
        act_next  = !lastw;
        bit_next  = 5'h00;
        slot_next = lastw ? 3'h0 : 3'(slot_reg + 3'h1);
      end else if (rise && act_reg) begin
        bit_next = 5'(bit_reg + 5'h01);
      end
      // frame sync made here changes on the falling edge that drives the last bit
      if (fall && ifs && !tslave) begin
        if (!act_reg || (bit_reg == wl && lastw)) begin
          fso_next = (mode == qsp_pkg::MODE_I2S) ? !fso_reg : 1'b1;
        end else if (mode != qsp_pkg::MODE_I2S) begin
          fso_next = 1'b0;
        end
      end
      if (!en) begin
        act_next = 1'b0;
        bit_next = 5'h00;
        fso_next = 1'b0;
      end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        act_reg  <= 1'b0;
        bit_reg  <= 5'h00;
        slot_reg <= 3'h0;
        fsl_reg  <= 1'b0;
        fso_reg  <= 1'b0;
        fsoe_reg <= 1'b0;
      end else begin
        act_reg  <= act_next;
        bit_reg  <= bit_next;
        slot_reg <= slot_next;
        fsl_reg  <= fsl_next;
        fso_reg  <= fso_next;
        fsoe_reg <= fsoe_next;
      end
    end

    assign ctrl_a[p] = ctrl_reg;
    assign div_a[p]  = {16'h0000, div_reg};
    assign stat_a[p] = {25'h0, stk_reg, fsv, act_reg, en};
    assign sclk_o[p]  = sco_reg;
    assign sclk_oe[p] = scoe_reg;
    assign fs_o[p]    = fso_reg;
    assign fs_oe[p]   = fsoe_reg;

    // each lane shifts on its own; in i2s both lanes carry a stereo pair
    for (l = 0; l < 2; l++) begin : g_lane
      localparam int LI = 2 * p + l;
      logic [31:0] txw_reg, txw_next;       // word being sent
      logic [31:0] rxw_reg, rxw_next;       // word being gathered
      logic        do_reg, do_next;         // lane data out
      logic        doe_reg, doe_next;       // lane drive enable
      logic        dir_tx, tx_take, tx_urun, rx_push, rx_ovf, txb_valid, rxb_ready;
      logic [31:0] txb_data, rx_val;
      logic [4:0]  idx;

      always_comb begin
        idx     = lsbf ? bit_reg : 5'(wl - bit_reg);
        dir_tx  = (mode == qsp_pkg::MODE_TDM) ? (p >= 2) : ctrl_reg[qsp_pkg::CTRL_DIR0 + l];
        tx_take = en && dir_tx && load && txb_valid;
        tx_urun = en && dir_tx && load && !txb_valid;
        txw_next = txw_reg;
        if (en && dir_tx && load) begin
          if (!txb_valid) txw_next = 32'h0000_0000;
          else if (cmp == qsp_pkg::CMP_OFF) txw_next = txb_data;
          else txw_next = {24'h0, qsp_compress(txb_data[15:0], cmp == qsp_pkg::CMP_A)};
        end
        do_next = do_reg;
        if (fall && act_reg && dir_tx) do_next = txw_reg[idx];
        if (!en || !dir_tx) do_next = 1'b0;
        doe_next = en && dir_tx;
        // receive samples on the rising edge, upper bits of short words read zero when companding is off
        rxw_next = rxw_reg;
        rx_push  = 1'b0;
        rx_val   = rxw_reg;
        if (en && !dir_tx && rise && act_reg) begin
          rxw_next      = (bit_reg == 5'h00) ? 32'h0000_0000 : rxw_reg;
          rxw_next[idx] = sy2_reg[2+l];
          rx_push       = done;
          rx_val        = (cmp == qsp_pkg::CMP_OFF) ? rxw_next
                        : qsp_expand(rxw_next[7:0], cmp == qsp_pkg::CMP_A);
        end
        rx_ovf = rx_push && !rxb_ready;
      end

      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          txw_reg <= 32'h0000_0000;
          rxw_reg <= 32'h0000_0000;
          do_reg  <= 1'b0;
          doe_reg <= 1'b0;
        end else begin
          txw_reg <= txw_next;
          rxw_reg <= rxw_next;
          do_reg  <= do_next;
          doe_reg <= doe_next;
        end
      end

      // two words of slack each way so a short dma stall loses nothing
      qsp_buf2 #(.WIDTH(qsp_pkg::WORD_W)) u_txb (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .in_valid  (dma_tx_valid[LI]),
        .in_ready  (dma_tx_ready[LI]),
        .in_data   (dma_tx_data[LI]),
        .out_valid (txb_valid),
        .out_ready (tx_take),
        .out_data  (txb_data)
      );
      qsp_buf2 #(.WIDTH(qsp_pkg::WORD_W)) u_rxb (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .in_valid  (rx_push),
        .in_ready  (rxb_ready),
        .in_data   (rx_val),
        .out_valid (dma_rx_valid[LI]),
        .out_ready (dma_rx_ready[LI]),
        .out_data  (dma_rx_data[LI])
      );

      assign urun_v[l]  = tx_urun;
      assign ovf_v[l]   = rx_ovf;
      assign dat_o[LI]  = do_reg;
      assign dat_oe[LI] = doe_reg;
    end
  end
endmodule : qsp_top

// file: qsp_monitor.sv
`timescale 1ns/1ns
// watches register reads, port 0 pins and the lane 1 receive stream
module qsp_monitor (
  input wire logic                                               core_clk,
  input wire logic                                               rst_b,
  input wire logic [5:0]                                         reg_addr,
  input wire logic                                               reg_rd,
  input wire logic [31:0]                                        reg_rdata,
  input wire logic [qsp_pkg::NUM_PORTS-1:0]                      sclk_o,
  input wire logic [qsp_pkg::NUM_PORTS-1:0]                      sclk_oe,
  input wire logic [qsp_pkg::NUM_PORTS-1:0]                      fs_o,
  input wire logic [qsp_pkg::NUM_PORTS-1:0]                      fs_oe,
  input wire logic [qsp_pkg::NUM_LANES-1:0]                      dat_o,
  input wire logic [qsp_pkg::NUM_LANES-1:0]                      dat_oe,
  input wire logic [qsp_pkg::NUM_LANES-1:0]                      dma_tx_ready,
  input wire logic [qsp_pkg::NUM_LANES-1:0][qsp_pkg::WORD_W-1:0] dma_rx_data,
  input wire logic [qsp_pkg::NUM_LANES-1:0]                      dma_rx_valid,
  input wire logic [qsp_pkg::NUM_LANES-1:0]                      dma_rx_ready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // read data stands one cycle only, so a bus mux can or the slaves together
  chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  chk_rd_unmapped: assert property (reg_rd && reg_addr[3:2] == 2'h3 |=> reg_rdata == 32'h0)
    else $error("unmapped index read not zero");
  chk_ctrl_upper: assert property (reg_rd && reg_addr[3:2] == 2'h0 |=> reg_rdata[31:18] == 14'h0)
    else $error("control upper bits not zero");
  chk_reset_out: assert property ($rose(rst_b) |-> dma_tx_ready == 8'hff && dat_oe == 8'h0 && sclk_oe == 4'h0)
    else $error("outputs not at reset values");
  // a stalled receive word must neither vanish nor change
  chk_rx_valid_hold: assert property (dma_rx_valid[1] && !dma_rx_ready[1] |=> dma_rx_valid[1])
    else $error("receive word dropped while stalled");
  chk_rx_data_hold: assert property (dma_rx_valid[1] && !dma_rx_ready[1] |=> $stable(dma_rx_data[1]))
    else $error("receive word changed while stalled");
  // data and frame sync move only on or just after a falling bit clock
  chk_dat_edge: assert property (sclk_oe[0] && $past(sclk_oe[0], 2) && dat_oe[0] && $past(dat_oe[0])
    && $changed(dat_o[0]) |-> (!sclk_o[0] && $past(sclk_o[0])) || (!$past(sclk_o[0]) && $past(sclk_o[0], 2)))
    else $error("lane data changed away from falling clock");
  chk_fs_edge: assert property (sclk_oe[0] && $past(sclk_oe[0], 2) && fs_oe[0] && $past(fs_oe[0])
    && $changed(fs_o[0]) |-> (!sclk_o[0] && $past(sclk_o[0])) || (!$past(sclk_o[0]) && $past(sclk_o[0], 2)))
    else $error("frame sync changed away from falling clock");
  cov_rx_word: cover property ($rose(dma_rx_valid[1]));
  cov_fs_out: cover property (fs_oe[0] && $rose(fs_o[0]));
  cov_rx_stall: cover property (dma_rx_valid[1] && !dma_rx_ready[1]);
endmodule : qsp_monitor

bind qsp_top qsp_monitor u_mon (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .fs_o(fs_o), .fs_oe(fs_oe), .dat_o(dat_o),
  .dat_oe(dat_oe), .dma_tx_ready(dma_tx_ready), .dma_rx_data(dma_rx_data), .dma_rx_valid(dma_rx_valid),
  .dma_rx_ready(dma_rx_ready));

// file: qsp_peer.sv
`timescale 1ns/1ns
// codec stand-in: echoes lane 0 back on lane 1 and keeps the latest framed word of lane 0
module qsp_peer (
  input  wire logic       ext_on,
  input  wire logic [3:0] sclk_o,
  input  wire logic [3:0] sclk_oe,
  input  wire logic [3:0] fs_o,
  input  wire logic [3:0] fs_oe,
  input  wire logic [7:0] dat_o,
  input  wire logic [7:0] dat_oe,
  output wire logic [3:0] sclk_i,
  output wire logic [3:0] fs_i,
  output wire logic [7:0] dat_i,
  output logic      [7:0] seen,
  output logic      [7:0] n_words
);
  logic       ext_clk = 1'b1;  // far-side bit clock, 800 ns, stands high outside use
  logic [3:0] fs_last = 4'h0;  // last level driven on each frame sync pin
  logic [7:0] sh = 8'h00;      // bits heard on lane 0
  initial seen = 8'h00;
  initial n_words = 8'h00;
  // far side makes the clock only when told to, well under half the core rate
  always #400 ext_clk = ext_on ? ~ext_clk : 1'b1;
  // clock and data pins have pull-ups; a released frame sync shows the inverse of its last level
  assign sclk_i = (sclk_oe & sclk_o) | (~sclk_oe & {3'h7, ext_clk});
  always @(fs_o or fs_oe) if (!$isunknown(fs_oe)) fs_last = (fs_oe & fs_o) | (~fs_oe & fs_last);
  assign fs_i = (fs_oe & fs_o) | (~fs_oe & ~fs_last);
  assign dat_i = (dat_oe & dat_o) | (~dat_oe & {6'h3f, dat_oe[0] ? dat_o[0] : 1'b1, 1'b1});
  // frame sync high on a rising edge marks the last bit of a word
  always @(posedge sclk_i[0]) begin
    sh = {sh[6:0], dat_i[0]};
    if (fs_i[0]) begin
      seen = sh;
      n_words = n_words + 8'h01;
    end
  end
endmodule : qsp_peer

// file: tb_quad_sync_serial_port.sv
`timescale 1ns/1ns
// register and loopback checks of the quad serial port block
module tb_quad_sync_serial_port;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, ext_on = 1'b0;
  wire logic [3:0] sclk_i, sclk_o, sclk_oe, fs_i, fs_o, fs_oe;
  wire logic [7:0] dat_i, dat_o, dat_oe, tx_r, rx_v, seen, n_words;
  logic [7:0] tx_v = 8'h00, rx_r = 8'hff, k;
  logic [7:0][31:0] tx_d = 256'h0;
  wire logic [7:0][31:0] rx_d;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  // per case: control word, word seen on the wire, expected receive value and its mask
  logic [31:0] cfg[4] = '{32'h61c2, 32'h61e2, 32'h69c2, 32'h51c2};
  logic [31:0] sexp[4] = '{32'h35, 32'hac, 32'hf8, 32'hd6};
  logic [31:0] rexp[4] = '{32'h35, 32'h35, 32'h38, 32'h38};
  logic [31:0] rmsk[4] = '{32'hff, 32'hff, 32'hffffffff, 32'hffffffff};
  qsp_top uut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk_i(sclk_i), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .fs_i(fs_i),
    .fs_o(fs_o), .fs_oe(fs_oe), .dat_i(dat_i), .dat_o(dat_o), .dat_oe(dat_oe), .dma_tx_data(tx_d),
    .dma_tx_valid(tx_v), .dma_tx_ready(tx_r), .dma_rx_data(rx_d), .dma_rx_valid(rx_v), .dma_rx_ready(rx_r));
  qsp_peer u_peer (.ext_on(ext_on), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .fs_o(fs_o), .fs_oe(fs_oe),
    .dat_o(dat_o), .dat_oe(dat_oe), .sclk_i(sclk_i), .fs_i(fs_i), .dat_i(dat_i), .seen(seen), .n_words(n_words));
  always #50 core_clk = ~core_clk;
  // hang guard, far above the roughly 1400 cycles the run needs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one strobe cycle, then one idle cycle so strobes never get assigned twice in a step
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] exp, input logic [31:0] msk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    check(reg_rdata & msk, exp);
  endtask : rd
  initial begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rd(6'h10, 32'h7c0, 32'hffffffff);
    rd(6'h14, 32'h4, 32'hffffffff);
    rd(6'h18, 32'h4, 32'hffffffff);
    rd(6'h1c, 32'h0, 32'hffffffff);
    wr(6'h10, 32'hfffffffe);
    rd(6'h10, 32'h3fffe, 32'hffffffff);
    rd(6'h00, 32'h7c0, 32'hffffffff);
    wr(6'h14, 32'h1234);
    wr(6'h10, 32'h1);
    wr(6'h10, 32'h7c1);
    wr(6'h14, 32'h7);
    rd(6'h10, 32'h1, 32'hffffffff);
    rd(6'h14, 32'h1234, 32'hffffffff);
    wr(6'h10, 32'h0);
    // port 0: lane 0 sends, lane 1 hears it back; receiver stalls so its buffer overflows
    for (int c = 0; c < 4; c++) begin
      tx_d[0] <= 32'h35;
      tx_v[0] <= 1'b1;
      rx_r[1] <= 1'b0;
      wr(6'h04, 32'h3);
      wr(6'h00, cfg[c]);
      check({31'h0, tx_r[0]}, 32'h0);
      ext_on <= (c == 3);
      wr(6'h00, cfg[c] | 32'h1);
      k = n_words;
      while (8'(n_words - k) < 8'h05) @(posedge core_clk);
      rd(6'h08, 32'h40, 32'h40);
      check({24'h0, seen}, sexp[c]);
      wr(6'h00, cfg[c]);
      tx_v[0] <= 1'b0;
      ext_on <= 1'b0;
      wr(6'h08, 32'h78);
      rd(6'h08, 32'h0, 32'h78);
      check(rx_d[1] & rmsk[c], rexp[c]);
      rx_r[1] <= 1'b1;
      @(posedge core_clk);
      while (rx_v[1]) @(posedge core_clk);
    end
    // i2s: first word comes back on lane 1
    rx_r[1] <= 1'b0;
    wr(6'h00, 32'h61d3);
    repeat (200) @(posedge core_clk);
    check(rx_d[1], 32'h35);
    end_of_test();
  end
endmodule : tb_quad_sync_serial_port
